//--- bench/cdd_ctrl_sva.sv
`default_nettype none
`include "cdd_regs.vh"
// ***********************************************
// Port checker for the control block
// ***********************************************
module cdd_ctrl_sva (
	// Clock, reset, host
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic host_req,
	input wire logic host_wr,
	input wire logic [10:0] host_addr,
	input wire logic [5:0] protocol_state_field,
	// Straps and internal sources
	input wire logic host_mode_strap,
	input wire logic bus_mux_strap,
	input wire logic cycle_start_pulse,
	input wire logic macrotick_pulse,
	input wire logic dyn_segment_start,
	input wire logic cycle_zero_start,
	input wire logic monitor_tx_a,
	input wire logic monitor_rx_a,
	input wire logic monitor_tx_b,
	input wire logic monitor_rx_b,
	// Outputs watched
	input wire logic clk_stopped_r,
	input wire logic op_clk_en_r,
	input wire logic ram_clk_en_r,
	input wire logic cycle_start_pin_r,
	input wire logic macrotick_pin_r,
	input wire logic dyn_segment_pin_r,
	input wire logic cycle_zero_pin_r,
	input wire logic [3:0] monitor_pins_r,
	input wire logic xfer_req_oe_r
);
	timeunit 1ns;
	timeprecision 100ps;
	// Clock word write in an admitting state
	wire cfg_st = protocol_state_field == `CDD_POCS_DEFAULT_CONFIG ||
		protocol_state_field == `CDD_POCS_CONFIG;
	wire clk_wr_ok = host_req && host_wr && clk_en && cfg_st &&
		host_addr == `CDD_OFF_CLK;
	// Monitor sources in pin order
	wire [3:0] mon_src = {monitor_rx_b, monitor_tx_b, monitor_rx_a,
		monitor_tx_a};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_cyc_pin_src: assert property (
		$past(clk_en) && cycle_start_pin_r |-> $past(cycle_start_pulse))
		else $error("cycle start pin high without source");
	a_mt_pin_src: assert property (
		$past(clk_en) && macrotick_pin_r |-> $past(macrotick_pulse))
		else $error("macrotick pin high without source");
	a_dyn_pin_src: assert property (
		$past(clk_en) && dyn_segment_pin_r |-> $past(dyn_segment_start))
		else $error("dynamic segment pin high without source");
	a_cz_pin_src: assert property (
		$past(clk_en) && cycle_zero_pin_r |-> $past(cycle_zero_start))
		else $error("cycle zero pin high without source");
	a_mon_pin_src: assert property (
		$past(clk_en) |-> (monitor_pins_r & ~$past(mon_src)) == 4'h0)
		else $error("monitor pin high without source");
	a_mon_mode_off: assert property (
		host_mode_strap && !bus_mux_strap |-> monitor_pins_r == 4'h0)
		else $error("monitor pins active in plain parallel mode");
	a_req_oe_serial: assert property (
		!host_mode_strap |-> !xfer_req_oe_r)
		else $error("request pin driven in serial mode");
	a_stop_gates: assert property (
		clk_stopped_r [*3] |-> !op_clk_en_r && !ram_clk_en_r)
		else $error("clock enables run while stopped");
	a_clk_cfg_only: assert property (
		$rose(clk_stopped_r) |-> $past(clk_wr_ok) || $past(clk_wr_ok, 2))
		else $error("clock stop set without admitted write");
endmodule
bind cdd_ctrl cdd_ctrl_sva u_sva (
	.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
	.host_req(host_req), .host_wr(host_wr), .host_addr(host_addr),
	.protocol_state_field(protocol_state_field),
	.host_mode_strap(host_mode_strap), .bus_mux_strap(bus_mux_strap),
	.cycle_start_pulse(cycle_start_pulse),
	.macrotick_pulse(macrotick_pulse),
	.dyn_segment_start(dyn_segment_start),
	.cycle_zero_start(cycle_zero_start), .monitor_tx_a(monitor_tx_a),
	.monitor_rx_a(monitor_rx_a), .monitor_tx_b(monitor_tx_b),
	.monitor_rx_b(monitor_rx_b), .clk_stopped_r(clk_stopped_r),
	.op_clk_en_r(op_clk_en_r), .ram_clk_en_r(ram_clk_en_r),
	.cycle_start_pin_r(cycle_start_pin_r),
	.macrotick_pin_r(macrotick_pin_r),
	.dyn_segment_pin_r(dyn_segment_pin_r),
	.cycle_zero_pin_r(cycle_zero_pin_r),
	.monitor_pins_r(monitor_pins_r), .xfer_req_oe_r(xfer_req_oe_r));
`default_nettype wire

//--- bench/cdd_host.sv
`default_nettype none
// ***********************************************
// Host CPU model on the register port
// ***********************************************
module cdd_host (
	// Clock and answer
	input wire logic sys_clk,
	input wire logic host_ack_r,
	input wire logic [31:0] host_rdata_r,
	// Request
	output var logic host_req,
	output var logic host_wr,
	output var logic [10:0] host_addr,
	output var logic [31:0] host_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		host_req = 1'b0;
		host_wr = 1'b0;
		host_addr = 11'h7ff;
		host_wdata = 32'h0;
	end
	// One access; held for its taking edge only, since a
	// longer hold would be taken again as a second request
	task automatic xfer(input logic w, input logic [10:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		@(posedge sys_clk);
		host_req <= 1'b1;
		host_wr <= w;
		host_addr <= a;
		host_wdata <= d;
		@(posedge sys_clk);
		host_req <= 1'b0;
		// Released lines show garbage, not the old value
		host_addr <= ~a;
		host_wdata <= ~d;
		@(negedge sys_clk);
		ok = host_ack_r;
		q = host_rdata_r;
	endtask
endmodule
`default_nettype wire

//--- bench/clock_debug_dma_control_regs_tb_top.sv
`default_nettype none
// ***********************************************
// Register sequence bench
// ***********************************************
module clock_debug_dma_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
	logic mode = 1'b1, mux = 1'b0;
	logic [1:0] freq = 2'h2;
	logic [5:0] state = 6'h00;
	// Sources: req, rx_b, tx_b, rx_a, tx_a, cz, dyn, mt, cyc
	logic [8:0] src = 9'h0;
	wire host_req, host_wr, ack, pll_power_on, psel, stopped, op_en, ram_en;
	wire p_cyc, p_mt, p_dyn, p_cz, req_out, req_oe;
	wire [10:0] addr;
	wire [31:0] wdata, rdata;
	wire [1:0] mul;
	wire [3:0] mon;
	// Pin snapshot: debug pins, monitors, oe, request
	wire [9:0] pins = {p_cyc, p_mt, p_dyn, p_cz, mon, req_oe, req_out};
	int miscompares = 0, total_checks = 0, cyc_n = 0, d, n_op, n_ram;
	cdd_host host (.sys_clk(sys_clk), .host_ack_r(ack),
		.host_rdata_r(rdata), .host_req(host_req), .host_wr(host_wr),
		.host_addr(addr), .host_wdata(wdata));
	cdd_ctrl uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
		.host_req(host_req), .host_wr(host_wr), .host_addr(addr),
		.host_wdata(wdata), .host_rdata_r(rdata), .host_ack_r(ack),
		.host_mode_strap(mode), .bus_mux_strap(mux),
		.freq_strap_high(freq[1]), .freq_strap_low(freq[0]),
		.protocol_state_field(state), .cycle_start_pulse(src[0]),
		.macrotick_pulse(src[1]), .dyn_segment_start(src[2]),
		.cycle_zero_start(src[3]), .monitor_tx_a(src[4]),
		.monitor_rx_a(src[5]), .monitor_tx_b(src[6]),
		.monitor_rx_b(src[7]), .xfer_req_int(src[8]),
		.pll_power_on_r(pll_power_on), .pll_select_r(psel),
		.pll_multiplier_r(mul), .op_clk_en_r(op_en),
		.ram_clk_en_r(ram_en), .clk_stopped_r(stopped),
		.cycle_start_pin_r(p_cyc), .macrotick_pin_r(p_mt),
		.dyn_segment_pin_r(p_dyn), .cycle_zero_pin_r(p_cz),
		.monitor_pins_r(mon), .xfer_req_out_r(req_out),
		.xfer_req_oe_r(req_oe));
	// 25 ns period
	always #12.5 sys_clk = ~sys_clk;
	// Hang guard; the lock wait alone is 24000 cycles
	always @(posedge sys_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 40000) begin
			miscompares++;
			stop_test();
		end
	end
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h exp %h", $time, msg,
				seen, exp);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] dat);
		logic [31:0] q;
		logic ok;
		host.xfer(1'b1, a, dat, q, ok);
		chk({31'h0, ok}, 32'h1, "missing ack");
	endtask
	task automatic rd(input logic [10:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic ok;
		host.xfer(1'b0, a, 32'h0, q, ok);
		chk({31'h0, ok}, 32'h1, "missing ack");
		chk(q, exp, "read data");
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Straps change only under reset; 4 edges before first access
	task automatic do_reset(input logic m);
		rst_b <= 1'b0;
		mode <= m;
		settle(3);
		rst_b <= 1'b1;
		settle(4);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		do_reset(1'b1);
		rd(11'h004, 32'h0);
		rd(11'h008, 32'h0);
		rd(11'h010, 32'h0);
		$display("test reset done");
		wr(11'h004, 32'h0000_000c);
		wr(11'h004, 32'h0000_000d);
		settle(24000);
		wr(11'h004, 32'h0000_000f);
		chk({27'h0, pll_power_on, psel, mul}, 32'hf, "pll fields");
		wr(11'h004, 32'h0000_000d);
		wr(11'h004, 32'h0000_000c);
		wr(11'h004, 32'h0000_01bc);
		rd(11'h004, 32'h0000_01bc);
		settle(8);
		chk({31'h0, stopped}, 32'h1, "stop flag");
		state <= 6'h15;
		wr(11'h004, 32'h0);
		rd(11'h004, 32'h0000_01bc);
		state <= 6'h0f;
		for (d = 0; d < 4; d++) begin
			wr(11'h004, {23'h0, d[1:0], 2'h0, d[0], 4'h0});
			settle(4);
			n_op = 0;
			n_ram = 0;
			repeat (32) begin
				@(negedge sys_clk);
				n_op += (op_en === 1'b1);
				n_ram += (ram_en === 1'b1);
			end
			chk(n_op, 32 >> d, "operating ticks");
			chk(n_ram, d[0] ? 16 : 32, "ram ticks");
		end
		$display("test clock done");
		src <= 9'h1ff;
		wr(11'h008, 32'h0000_0004);
		wr(11'h008, 32'hf800_0007);
		rd(11'h008, 32'hf800_0007);
		settle(2);
		chk({22'h0, pins}, 32'h3c2, "pins all on");
		wr(11'h008, 32'h0000_0003);
		settle(2);
		chk({22'h0, pins}, 32'h003, "pins gated");
		wr(11'h008, 32'h0000_0001);
		settle(2);
		chk({22'h0, pins}, 32'h002, "request off");
		wr(11'h008, 32'h0);
		settle(2);
		chk({22'h0, pins}, 32'h000, "pin released");
		$display("test debug done");
		do_reset(1'b0);
		rd(11'h004, 32'h0000_0009);
		wr(11'h008, 32'h4000_0004);
		wr(11'h008, 32'h4000_0007);
		settle(2);
		chk({22'h0, pins}, 32'h03c, "serial pins");
		// Enable low must freeze every pin despite new sources
		clk_en <= 1'b0;
		src <= 9'h0;
		settle(3);
		chk({22'h0, pins}, 32'h03c, "frozen pins");
		clk_en <= 1'b1;
		settle(2);
		chk({22'h0, pins}, 32'h001, "thawed pins");
		$display("test serial done");
		stop_test();
	end
endmodule
`default_nettype wire

//--- design/cdd_clkdiv.v
`default_nettype none
// ***********************************************
// Operating and RAM clock enable generator
// ***********************************************
`include "cdd_regs.vh"
module cdd_clkdiv (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// Settings
	input wire [1:0] div_sel,
	input wire ram_half,
	input wire stop,
	// Enables for downstream logic
	output reg op_tick_r,
	output reg ram_tick_r
);
	reg [2:0] cnt_r; // Free prescale count
	reg [2:0] mask; // Low bits that must all be set

	// Mask for the chosen division
	always @* begin
		case (div_sel)
			2'h0: mask = `CDD_MASK_DIV1;
			2'h1: mask = `CDD_MASK_DIV2;
			2'h2: mask = `CDD_MASK_DIV4;
			default: mask = `CDD_MASK_DIV8;
		endcase
	end

	// Count holds while stopped, so phase is kept
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			cnt_r <= 3'h0;
			op_tick_r <= `CDD_RST_BIT;
			ram_tick_r <= `CDD_RST_BIT;
		end else if (clk_en) begin
			if (stop) begin
				// Gated: no ticks at all
				op_tick_r <= 1'b0;
				ram_tick_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r + 3'h1;
				op_tick_r <= ((cnt_r & mask) == mask);
				ram_tick_r <= ram_half ? cnt_r[0] : 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- design/cdd_ctrl.v
// Operation
// - Reserved bits read zero, host writes zero
// - Divider field sets protocol engine clock
// - Divider codes: by one, two, four, eight
// - Clock stop gates system clock off
// - RAM select picks system clock or half
// - RAM select zero direct, one halved
// - Multiplier codes target eighty megahertz PLL
// - Serial mode loads straps, enables PLL
// - Source select and PLL enable drive clocks
// - Clock writes only in configuration states
// - Monitor pins follow enable, else low; held low in plain parallel mode
// - Cycle start pin gated by bit 31
// - Macrotick, dynamic, cycle zero pins gated
// - Polarity bit inverts request while driven
// - Request enable suppresses requests when zero
// - Drive enable drives pin, else high impedance
// - Serial mode: request register has no effect
`default_nettype none
`include "cdd_regs.vh"
module cdd_ctrl (
	// Clock, reset, enable
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// Host register port
	input wire host_req,
	input wire host_wr,
	input wire [10:0] host_addr,
	input wire [31:0] host_wdata,
	output reg [31:0] host_rdata_r,
	output reg host_ack_r,
	// Mode and frequency straps (pins)
	input wire host_mode_strap,
	input wire bus_mux_strap,
	input wire freq_strap_high,
	input wire freq_strap_low,
	// Protocol engine status
	input wire [5:0] protocol_state_field,
	// Internal timing and monitor signals
	input wire cycle_start_pulse,
	input wire macrotick_pulse,
	input wire dyn_segment_start,
	input wire cycle_zero_start,
	input wire monitor_tx_a,
	input wire monitor_rx_a,
	input wire monitor_tx_b,
	input wire monitor_rx_b,
	input wire xfer_req_int,
	// Clock control outputs
	output reg pll_power_on_r,
	output reg pll_select_r,
	output reg [1:0] pll_multiplier_r,
	output reg op_clk_en_r,
	output reg ram_clk_en_r,
	output reg clk_stopped_r,
	// Debug pins
	output reg cycle_start_pin_r,
	output reg macrotick_pin_r,
	output reg dyn_segment_pin_r,
	output reg cycle_zero_pin_r,
	output reg [3:0] monitor_pins_r,
	// Transfer request pin
	output reg xfer_req_out_r,
	output reg xfer_req_oe_r
);
	// ***********************************************
	// Declarations
	// ***********************************************
	// Clock control fields
	reg [1:0] sys_clock_divider_r; // Operating clock division
	reg ram_half_r; // RAM clock at half rate
	reg stop_r; // Clock stop request
	// Debug enables
	reg cycle_start_out_enable_r;
	reg bus_monitor_output_enable_r;
	reg macrotick_out_enable_r;
	reg dyn_segment_out_enable_r;
	reg cycle_zero_out_enable_r;
	// Transfer request control
	reg request_polarity_r; // One means active low
	reg request_enable_r; // Requests allowed
	reg request_drive_enable_r; // Pin driven
	// Strap synchroniser, first stage then second
	reg [3:0] strap_meta_r;
	reg [3:0] strap_sync_r;
	// Strap capture sequencing
	reg [1:0] strap_wait_r;
	reg serial_mode_r; // Caught serial host mode
	reg mux_mode_r; // Caught multiplexed bus mode
	// Decodes
	wire wr_clk;
	wire wr_dbg;
	wire rd_clk;
	wire rd_dbg;
	wire cfg_state;
	wire strap_load;
	wire host_open;
	wire mon_active;
	wire req_level;
	// Divider outputs
	wire op_tick;
	wire ram_tick;
	// Assembled read words
	wire [31:0] clk_word;
	wire [31:0] dbg_word;

	// ***********************************************
	// Address decode
	// ***********************************************
	// Straps load before any host write is taken
	assign host_open = (strap_wait_r == `CDD_STRAP_DONE);
	assign strap_load = (strap_wait_r == `CDD_STRAP_LOAD);
	// Clock writes only in the configuration states
	assign cfg_state =
		(protocol_state_field == `CDD_POCS_DEFAULT_CONFIG) ||
		(protocol_state_field == `CDD_POCS_CONFIG);
	assign wr_clk = host_req && host_wr && host_open &&
		(host_addr == `CDD_OFF_CLK) && cfg_state;
	assign wr_dbg = host_req && host_wr && host_open &&
		(host_addr == `CDD_OFF_DBG);
	assign rd_clk = (host_addr == `CDD_OFF_CLK);
	assign rd_dbg = (host_addr == `CDD_OFF_DBG);

	// ***********************************************
	// Read words, reserved bits zero
	// ***********************************************
	// Gaps filled with zeros
	assign clk_word = {23'h000000,
		sys_clock_divider_r,
		1'b0,
		stop_r,
		ram_half_r,
		pll_multiplier_r,
		pll_select_r,
		pll_power_on_r};
	assign dbg_word = {cycle_start_out_enable_r,
		bus_monitor_output_enable_r,
		macrotick_out_enable_r,
		dyn_segment_out_enable_r,
		cycle_zero_out_enable_r,
		11'h000,
		13'h0000,
		request_polarity_r,
		request_enable_r,
		request_drive_enable_r};

	// ***********************************************
	// Strap synchroniser
	// ***********************************************
	// Straps are pins; no reset so they settle freely
	always @(posedge sys_clk) begin
		if (clk_en) begin
			strap_meta_r <= {bus_mux_strap, host_mode_strap,
				freq_strap_high, freq_strap_low};
			strap_sync_r <= strap_meta_r;
		end
	end

	// Wait two edges after release for settled straps
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			strap_wait_r <= `CDD_RST_2B;
			serial_mode_r <= `CDD_RST_BIT;
			mux_mode_r <= `CDD_RST_BIT;
		end else if (clk_en) begin
			if (!host_open) begin
				strap_wait_r <= strap_wait_r + 2'h1;
			end
			if (strap_load) begin
				// Mode strap low selects serial host
				serial_mode_r <= ~strap_sync_r[2];
				mux_mode_r <= strap_sync_r[3];
			end
		end
	end

	// ***********************************************
	// Clock control register
	// ***********************************************
	// Held through clock stop; bus stays live
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			pll_power_on_r <= `CDD_RST_BIT;
			pll_select_r <= `CDD_RST_BIT;
			pll_multiplier_r <= `CDD_RST_2B;
			ram_half_r <= `CDD_RST_BIT;
			stop_r <= `CDD_RST_BIT;
			sys_clock_divider_r <= `CDD_RST_2B;
		end else if (clk_en) begin
			if (strap_load && !strap_sync_r[2]) begin
				// Serial host: straps pick the multiplier
				pll_multiplier_r <= strap_sync_r[1:0];
				pll_power_on_r <= 1'b1;
			end else if (wr_clk) begin
				// Host keeps ordering of these fields
				pll_power_on_r <=
					host_wdata[`CDD_CLK_PON];
				pll_select_r <=
					host_wdata[`CDD_CLK_SEL];
				pll_multiplier_r <= host_wdata[
					`CDD_CLK_MUL_HI:`CDD_CLK_MUL_LO];
				ram_half_r <= host_wdata[`CDD_CLK_RAM];
				stop_r <= host_wdata[`CDD_CLK_STOP];
				sys_clock_divider_r <= host_wdata[
					`CDD_CLK_DIV_HI:`CDD_CLK_DIV_LO];
			end
		end
	end

	// ***********************************************
	// Debug and transfer request register
	// ***********************************************
	// Both halves share one word
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			cycle_start_out_enable_r <= `CDD_RST_BIT;
			bus_monitor_output_enable_r <= `CDD_RST_BIT;
			macrotick_out_enable_r <= `CDD_RST_BIT;
			dyn_segment_out_enable_r <= `CDD_RST_BIT;
			cycle_zero_out_enable_r <= `CDD_RST_BIT;
			request_polarity_r <= `CDD_RST_BIT;
			request_enable_r <= `CDD_RST_BIT;
			request_drive_enable_r <= `CDD_RST_BIT;
		end else if (clk_en && wr_dbg) begin
			cycle_start_out_enable_r <=
				host_wdata[`CDD_DBG_CYC];
			bus_monitor_output_enable_r <=
				host_wdata[`CDD_DBG_MON];
			macrotick_out_enable_r <=
				host_wdata[`CDD_DBG_MT];
			dyn_segment_out_enable_r <=
				host_wdata[`CDD_DBG_DYN];
			cycle_zero_out_enable_r <=
				host_wdata[`CDD_DBG_CYC0];
			// Stored even in serial mode; only unused there
			request_polarity_r <= host_wdata[`CDD_DMA_POL];
			request_enable_r <= host_wdata[`CDD_DMA_EN];
			request_drive_enable_r <= host_wdata[`CDD_DMA_OE];
		end
	end

	// ***********************************************
	// Host answer
	// ***********************************************
	// One-cycle ack; unmapped addresses read zero
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			host_rdata_r <= `CDD_RST_WORD;
			host_ack_r <= `CDD_RST_BIT;
		end else if (clk_en) begin
			host_ack_r <= host_req && host_open;
			if (host_req && host_open && !host_wr) begin
				if (rd_clk) begin
					host_rdata_r <= clk_word;
				end else if (rd_dbg) begin
					host_rdata_r <= dbg_word;
				end else begin
					host_rdata_r <= `CDD_RST_WORD;
				end
			end
		end
	end

	// ***********************************************
	// Clock division and stop
	// ***********************************************
	cdd_clkdiv u_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.div_sel(sys_clock_divider_r),
		.ram_half(ram_half_r),
		.stop(stop_r),
		.op_tick_r(op_tick),
		.ram_tick_r(ram_tick)
	);

	// Registered again so outputs come from flops here
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			op_clk_en_r <= `CDD_RST_BIT;
			ram_clk_en_r <= `CDD_RST_BIT;
			clk_stopped_r <= `CDD_RST_BIT;
		end else if (clk_en) begin
			op_clk_en_r <= op_tick & ~stop_r;
			ram_clk_en_r <= ram_tick & ~stop_r;
			clk_stopped_r <= stop_r;
		end
	end

	// ***********************************************
	// Debug pins
	// ***********************************************
	// Monitor pins only exist in serial or mux modes
	assign mon_active = bus_monitor_output_enable_r &
		(serial_mode_r | mux_mode_r);
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			cycle_start_pin_r <= `CDD_RST_BIT;
			macrotick_pin_r <= `CDD_RST_BIT;
			dyn_segment_pin_r <= `CDD_RST_BIT;
			cycle_zero_pin_r <= `CDD_RST_BIT;
			monitor_pins_r <= 4'h0;
		end else if (clk_en) begin
			cycle_start_pin_r <= cycle_start_pulse &
				cycle_start_out_enable_r;
			macrotick_pin_r <= macrotick_pulse &
				macrotick_out_enable_r;
			dyn_segment_pin_r <= dyn_segment_start &
				dyn_segment_out_enable_r;
			cycle_zero_pin_r <= cycle_zero_start &
				cycle_zero_out_enable_r;
			monitor_pins_r <= {monitor_rx_b, monitor_tx_b,
				monitor_rx_a, monitor_tx_a} &
				{4{mon_active}};
		end
	end

	// ***********************************************
	// Transfer request pin
	// ***********************************************
	// Polarity is applied even while undriven, so a
	// host that sets it first sees no glitch
	assign req_level = request_polarity_r ^
		(xfer_req_int & request_enable_r);
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			xfer_req_out_r <= `CDD_RST_BIT;
			xfer_req_oe_r <= `CDD_RST_BIT;
		end else if (clk_en) begin
			xfer_req_out_r <= req_level;
			// No pin in serial mode: never driven
			xfer_req_oe_r <= request_drive_enable_r &
				~serial_mode_r;
		end
	end
endmodule
`default_nettype wire

//--- design/cdd_regs.vh
`ifndef CDD_REGS_VH
`define CDD_REGS_VH
// ***********************************************
// Register offsets (byte addresses)
// ***********************************************
`define CDD_OFF_CLK 11'h004
`define CDD_OFF_DBG 11'h008
// ***********************************************
// Clock control field positions
// ***********************************************
`define CDD_CLK_PON 0
`define CDD_CLK_SEL 1
`define CDD_CLK_MUL_LO 2
`define CDD_CLK_MUL_HI 3
`define CDD_CLK_RAM 4
`define CDD_CLK_STOP 5
`define CDD_CLK_DIV_LO 7
`define CDD_CLK_DIV_HI 8
// ***********************************************
// Debug pin enable and transfer request fields
// ***********************************************
`define CDD_DBG_CYC 31
`define CDD_DBG_MON 30
`define CDD_DBG_MT 29
`define CDD_DBG_DYN 28
`define CDD_DBG_CYC0 27
`define CDD_DMA_POL 2
`define CDD_DMA_EN 1
`define CDD_DMA_OE 0
// ***********************************************
// Reset values
// ***********************************************
`define CDD_RST_BIT 1'b0
`define CDD_RST_2B 2'h0
`define CDD_RST_WORD 32'h0000_0000
// ***********************************************
// Protocol state codes that admit clock writes
// ***********************************************
`define CDD_POCS_DEFAULT_CONFIG 6'h00
`define CDD_POCS_CONFIG 6'h0f
// ***********************************************
// Strap capture timing
// ***********************************************
`define CDD_STRAP_LOAD 2'h2
`define CDD_STRAP_DONE 2'h3
// ***********************************************
// Divider masks
// ***********************************************
`define CDD_MASK_DIV1 3'h0
`define CDD_MASK_DIV2 3'h1
`define CDD_MASK_DIV4 3'h3
`define CDD_MASK_DIV8 3'h7
`endif
